// [pkg/sarcc_defs.svh]
`ifndef SARCC_DEFS_SVH
`define SARCC_DEFS_SVH

`define SARCC_RES_W 14
`define SARCC_CODE_MID 14'h2000
`define SARCC_CODE_ONES 14'h3FFF
`define SARCC_CODE_ZERO 14'h0000
`define SARCC_CONV_CYCLES 57
`define SARCC_CONV_LAST 6'h38
`define SARCC_DIV_W 2
`define SARCC_EOC_CYCLES 3'h4
`define SARCC_CLK_PERIOD_NS 25
`define SARCC_HOLD_EXTRA_NS 50
`define SARCC_HOLD_MIN_CYCLES ((`SARCC_CLK_PERIOD_NS + `SARCC_HOLD_EXTRA_NS + `SARCC_CLK_PERIOD_NS - 1) / `SARCC_CLK_PERIOD_NS)
`define SARCC_TRIM_W 6
`define SARCC_CLK_IDLE 5'h10
`define SARCC_FIFO_DEPTH 16

`endif

// [pkg/sarcc_pkg.sv]
`default_nettype none

package sarcc_pkg;

  typedef enum logic [2:0] {
    SARCC_TRACK = 3'b000,
    SARCC_SYNC = 3'b001,
    SARCC_CONV = 3'b010,
    SARCC_PUSH = 3'b011,
    SARCC_CAL = 3'b100
  } sarcc_state_t;

endpackage

`default_nettype wire

// [hw/sarcc_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module sarcc_fifo
#(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [hw/sarcc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sarcc_defs.svh"

module sarcc_ctrl
  import sarcc_pkg::*;
#(
  parameter int RES_W = `SARCC_RES_W,
  parameter int TRIM_W = `SARCC_TRIM_W,
  parameter int FIFO_DEPTH = `SARCC_FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic master_clock_in,
  input wire logic hold_b,
  input wire logic cs_b,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic low_address_bit,
  input wire logic bipolar,
  input wire logic comp_below,
  input wire logic over_range,
  input wire logic under_range,
  input wire logic cal_heavy,
  output logic clock_src_ext,
  output logic tracking,
  output logic msb_to_ref,
  output logic [RES_W-1:0] dac_code,
  output logic cal_active,
  output logic [3:0] cal_bit,
  output logic [TRIM_W-1:0] cal_trim,
  output logic eoc_b,
  output logic out_valid,
  input wire logic out_ready,
  output logic [RES_W-1:0] out_data
);

  sarcc_state_t state_q;
  logic [`SARCC_DIV_W-1:0] div_q;
  logic [5:0] cnt_q;
  logic [RES_W-1:0] sar_q;
  logic [RES_W-1:0] res_q;
  logic hold_q;
  logic wr_q;
  logic mclk_q;
  logic [4:0] idle_q;
  logic [TRIM_W-1:0] trim_q [RES_W];
  logic [3:0] cbit_q;
  localparam int STEP_W = $clog2(TRIM_W);
  logic [STEP_W-1:0] cstep_q;
  logic eoc_low_q;
  logic [2:0] eoc_cnt_q;
  logic hold_fall;
  logic wr_start;
  logic soft_rst;
  logic start;
  logic read_act;
  logic push_ready;
  logic [3:0] bit_idx;

  function automatic logic [RES_W-1:0] sarcc_onehot(input logic [3:0] idx);
    sarcc_onehot = RES_W'(1) << idx;
  endfunction

  assign hold_fall = hold_q && !hold_b;
  assign wr_start = wr_q && !wr_b && !cs_b && low_address_bit;
  assign soft_rst = !cs_b && !low_address_bit && !hold_b;
  // The strobe is retriggered by its level when tracking resumes, so a strobe held too long starts again.
  assign start = hold_fall || wr_start || (!hold_b && hold_q == 1'b0 && state_q == SARCC_TRACK);
  assign read_act = !cs_b && !rd_b;
  assign bit_idx = 4'(RES_W - 1) - cnt_q[5:2];

  assign tracking = (state_q == SARCC_TRACK);
  assign msb_to_ref = bipolar && tracking;
  assign dac_code = (state_q == SARCC_CONV) ? sar_q : '0;
  assign cal_active = (state_q == SARCC_CAL);
  assign cal_bit = cbit_q;
  assign cal_trim = trim_q[cbit_q];
  assign eoc_b = !eoc_low_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hold_q <= 1'b1;
      wr_q <= 1'b1;
      mclk_q <= 1'b0;
    end
    else
    begin
      hold_q <= hold_b;
      wr_q <= wr_b;
      mclk_q <= master_clock_in;
    end
  end

  // Clock source: no activity on the pin while it sits low selects the oscillator.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idle_q <= '0;
      clock_src_ext <= 1'b0;
    end
    else
    begin
      if (mclk_q != master_clock_in)
      begin
        idle_q <= '0;
        clock_src_ext <= 1'b1;
      end
      else if (idle_q != `SARCC_CLK_IDLE)
      begin
        idle_q <= idle_q + 1'b1;
      end
      else if (!master_clock_in)
      begin
        clock_src_ext <= 1'b0;
      end
    end
  end

  // Free-running quarter-rate phase; conversions align to it, which costs up to four cycles.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= SARCC_CAL;
      cnt_q <= '0;
      sar_q <= '0;
      res_q <= '0;
    end
    else if (soft_rst)
    begin
      state_q <= SARCC_CAL;
      cnt_q <= '0;
      sar_q <= '0;
    end
    else
    begin
      case (state_q)
        SARCC_TRACK:
        begin
          if (start)
          begin
            state_q <= SARCC_SYNC;
          end
        end
        SARCC_SYNC:
        begin
          if (div_q == '1)
          begin
            state_q <= SARCC_CONV;
            cnt_q <= '0;
            sar_q <= `SARCC_CODE_MID;
          end
        end
        SARCC_CONV:
        begin
          // Strobe edges are not looked at here, so a new fall cannot restart the array.
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == `SARCC_CONV_LAST)
          begin
            state_q <= SARCC_PUSH;
            if (over_range)
            begin
              res_q <= `SARCC_CODE_ONES;
            end
            else if (under_range)
            begin
              res_q <= `SARCC_CODE_ZERO;
            end
            else
            begin
              res_q <= sar_q;
            end
          end
          else if (cnt_q[1:0] == 2'h3)
          begin
            if (comp_below)
            begin
              sar_q[bit_idx] <= 1'b0;
            end
            if (bit_idx != 4'h0)
            begin
              sar_q[bit_idx - 1'b1] <= 1'b1;
            end
          end
        end
        SARCC_PUSH:
        begin
          // A full result queue stalls here, keeping the input held rather than losing a code.
          if (push_ready)
          begin
            state_q <= SARCC_TRACK;
          end
        end
        SARCC_CAL:
        begin
          if (cbit_q == 4'(RES_W - 1) && cstep_q == '0)
          begin
            state_q <= SARCC_TRACK;
          end
        end
        default:
        begin
          state_q <= SARCC_TRACK;
        end
      endcase
    end
  end

  // Calibration walks bits upward, binary-searching each trim against the lower sum plus one unit.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cbit_q <= 4'h1;
      cstep_q <= STEP_W'(TRIM_W - 1);
      for (int i = 0; i < RES_W; i++)
      begin
        trim_q[i] <= '0;
      end
      // The first bit must start with its top trim bit on, or its first search step tests nothing.
      trim_q[1] <= TRIM_W'(1) << (TRIM_W - 1);
    end
    else if (soft_rst)
    begin
      cbit_q <= 4'h1;
      cstep_q <= STEP_W'(TRIM_W - 1);
      trim_q[1] <= TRIM_W'(1) << (TRIM_W - 1);
    end
    else if (state_q == SARCC_CAL)
    begin
      if (cal_heavy)
      begin
        trim_q[cbit_q][cstep_q] <= 1'b0;
      end
      if (cstep_q != '0)
      begin
        trim_q[cbit_q][cstep_q - 1'b1] <= 1'b1;
        cstep_q <= cstep_q - 1'b1;
      end
      else if (cbit_q != 4'(RES_W - 1))
      begin
        cbit_q <= cbit_q + 1'b1;
        cstep_q <= STEP_W'(TRIM_W - 1);
        trim_q[cbit_q + 1'b1] <= TRIM_W'(1) << (TRIM_W - 1);
      end
    end
  end

  // End of conversion falls when a code is queued or calibration ends.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eoc_low_q <= 1'b0;
      eoc_cnt_q <= '0;
    end
    else if (soft_rst || (state_q == SARCC_TRACK && start))
    begin
      eoc_low_q <= 1'b0;
      eoc_cnt_q <= '0;
    end
    else if ((state_q == SARCC_PUSH && push_ready) || (state_q == SARCC_CAL && cbit_q == 4'(RES_W - 1)
             && cstep_q == '0))
    begin
      eoc_low_q <= 1'b1;
      eoc_cnt_q <= '0;
    end
    else if (eoc_low_q && (read_act || eoc_cnt_q != '0))
    begin
      if (eoc_cnt_q == `SARCC_EOC_CYCLES - 1'b1)
      begin
        eoc_low_q <= 1'b0;
        eoc_cnt_q <= '0;
      end
      else
      begin
        eoc_cnt_q <= eoc_cnt_q + 1'b1;
      end
    end
  end

  sarcc_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(state_q == SARCC_PUSH),
    .in_ready(push_ready),
    .in_data(res_q),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  sequence sarcc_conv_begin_s;
    state_q == SARCC_SYNC ##1 state_q == SARCC_CONV;
  endsequence

  chk_msb_first: assert property (@(posedge clk) disable iff (!rst_b)
    sarcc_conv_begin_s |-> dac_code == `SARCC_CODE_MID)
    else $error("first trial is not the top bit alone");

  chk_conv_length: assert property (@(posedge clk) disable iff (!rst_b || soft_rst)
    $rose(state_q == SARCC_CONV) |-> ##56 (state_q == SARCC_CONV) ##1 (state_q == SARCC_PUSH))
    else $error("conversion length wrong");

  chk_conv_exit: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == SARCC_CONV && !soft_rst) ##1 (state_q == SARCC_PUSH) |-> $past(cnt_q) == `SARCC_CONV_LAST)
    else $error("conversion left before 57 cycles");

  chk_sync_wait: assert property (@(posedge clk) disable iff (!rst_b || soft_rst)
    $rose(state_q == SARCC_SYNC) |-> ##[1:4] state_q == SARCC_CONV)
    else $error("alignment took more than four cycles");

  chk_hold_start: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == SARCC_TRACK && hold_fall && !soft_rst) |=> state_q == SARCC_SYNC)
    else $error("strobe fall did not start a conversion");

  chk_write_start: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == SARCC_TRACK && wr_start && !soft_rst) |=> state_q == SARCC_SYNC)
    else $error("write did not start a conversion");

  chk_ignore_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == SARCC_CONV && hold_fall && !soft_rst && cnt_q != `SARCC_CONV_LAST) |=> state_q == SARCC_CONV)
    else $error("strobe fall disturbed a conversion");

  chk_soft_reset: assert property (@(posedge clk) disable iff (!rst_b)
    soft_rst |=> state_q == SARCC_CAL && eoc_b)
    else $error("software reset not taken");

  chk_saturate_hi: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == SARCC_CONV && cnt_q == `SARCC_CONV_LAST && over_range && !soft_rst) |=> res_q == `SARCC_CODE_ONES)
    else $error("over-range code not all ones");

  chk_track_return: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == SARCC_PUSH && push_ready && !soft_rst) |=> tracking && !eoc_b)
    else $error("no return to tracking after conversion");

  chk_eoc_release: assert property (@(posedge clk) disable iff (!rst_b)
    (eoc_low_q && read_act && eoc_cnt_q == '0) |-> ##[1:4] eoc_b)
    else $error("end of conversion held past four cycles");

endmodule

`default_nettype wire

// [bench/sarcc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module sarcc_host_model
(
  input wire logic clk,
  output logic hold_b,
  output logic cs_b,
  output logic rd_b,
  output logic wr_b,
  output logic low_address_bit
);
  initial
  begin
    {hold_b, cs_b, rd_b, wr_b, low_address_bit} = 5'h1E;
  end

  task automatic drive(input logic [4:0] v);
    @(negedge clk);
    {hold_b, cs_b, rd_b, wr_b, low_address_bit} = v;
  endtask

  // Low time is clamped so that a careless caller can never retrigger a conversion.
  task automatic strobe(input int low);
    drive(5'h0E);
    repeat ((low < 3) ? 3 : ((low > 40) ? 40 : low)) @(negedge clk);
    {hold_b, cs_b, rd_b, wr_b, low_address_bit} = 5'h1E;
  endtask

  // The write goes to the odd address, so it never looks like a soft reset.
  task automatic write_start();
    drive(5'h1F);
    drive(5'h15);
    drive(5'h1F);
    drive(5'h1E);
  endtask

  task automatic read_begin();
    drive(5'h13);
  endtask

  task automatic release_bus();
    drive(5'h1E);
  endtask

  task automatic soft_reset();
    drive(5'h06);
    drive(5'h1E);
  endtask
endmodule

`default_nettype wire

// [bench/sarcc_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none

module sarcc_ctrl_test;
  import sarcc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic master_clock_in = 1'b0;
  logic bipolar = 1'b0;
  logic over_range = 1'b0;
  logic under_range = 1'b0;
  logic cal_heavy = 1'b0;
  logic out_ready = 1'b1;
  logic heavy_on = 1'b1;
  logic comp_below;
  logic hold_b, cs_b, rd_b, wr_b, low_address_bit;
  logic clock_src_ext, tracking, msb_to_ref, cal_active, eoc_b, out_valid;
  logic [3:0] cal_bit;
  logic [5:0] cal_trim;
  logic [13:0] dac_code, out_data;
  logic [13:0] analog_input = 14'h0000;
  logic [13:0] edge_v[4] = '{14'h0000, 14'h3FFF, 14'h2000, 14'h1FFF};
  logic [31:0] seed = 32'h16534ECC;
  logic [13:0] exp_q[$];
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0 = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(negedge clk) cal_heavy <= heavy_on && seed[cyc % 32];
  // The comparator is ideal, so a correct search lands exactly on the held input.
  assign comp_below = analog_input < dac_code;

  sarcc_ctrl dut
  (
    .clk(clk), .rst_b(rst_b), .master_clock_in(master_clock_in), .hold_b(hold_b), .cs_b(cs_b),
    .rd_b(rd_b), .wr_b(wr_b), .low_address_bit(low_address_bit), .bipolar(bipolar),
    .comp_below(comp_below), .over_range(over_range), .under_range(under_range), .cal_heavy(cal_heavy),
    .clock_src_ext(clock_src_ext), .tracking(tracking), .msb_to_ref(msb_to_ref), .dac_code(dac_code),
    .cal_active(cal_active), .cal_bit(cal_bit), .cal_trim(cal_trim), .eoc_b(eoc_b),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data)
  );

  sarcc_host_model host
  (
    .clk(clk), .hold_b(hold_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .low_address_bit(low_address_bit)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check_code(input logic [13:0] e, input logic [13:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic check_bit(input logic e, input logic g);
    check_code({13'h0000, e}, {13'h0000, g});
  endtask

  task automatic end_test(input string s);
    $display("done %s", s);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_on(input int which, input int lim);
    int n;
    n = 0;
    while ((which == 0) ? (tracking !== 1'b0) : !(eoc_b === 1'b0 && tracking === 1'b1))
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim)
      begin
        fails++;
        $display("BAD %0t exp %h got %h", $time, which, n);
        complete_run();
      end
    end
  endtask

  // Kinds: 0 strobe, 1 write, 2 strobe plus a stray one, 3 strobe without waiting.
  task automatic convert(input int how, input logic [13:0] a, input logic [1:0] ou);
    @(negedge clk);
    analog_input = a;
    {over_range, under_range} = ou;
    exp_q.push_back(ou[1] ? 14'h3FFF : (ou[0] ? 14'h0000 : a));
    t0 = cyc;
    if (how == 1)
      host.write_start(); // Write cycle start.
    else
      host.strobe(3); // Falling strobe start.
    if (how == 3)
      return;
    wait_on(0, 10);
    if (how == 2)
    begin
      repeat (8) @(negedge clk);
      host.strobe(3); // A strobe in mid-conversion is ignored.
    end
    wait_on(1, 80); // Tracking resumes unprompted.
    check_bit(1'b1, (cyc - t0 >= 57) && (cyc - t0 <= 66)); // Conversion length.
  endtask

  always @(posedge clk)
  begin
    if (rst_b && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        fails++;
        $display("BAD %0t exp %h got %h", $time, 14'h0000, out_data);
      end
      else
        check_code(exp_q.pop_front(), out_data); // Result code.
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    check_bit(1'b1, eoc_b);
    check_bit(1'b0, out_valid);
    rst_b = 1'b1;
    wait_on(1, 200);
    end_test("reset");
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      convert(i % 2, (i < 4) ? edge_v[i] : seed[13:0], 2'h0); // Search result.
    end
    end_test("unipolar");
    @(negedge clk);
    bipolar = 1'b1;
    @(negedge clk);
    check_bit(1'b1, msb_to_ref); // Top weight on the reference while tracking.
    convert(0, 14'h2000, 2'h0); // Midpoint code.
    convert(2, seed[13:0] ^ 14'h1555, 2'h0); // Only one result appears.
    end_test("bipolar");
    for (int j = 0; j < 6; j++)
    begin
      @(negedge clk);
      bipolar = (j >= 3);
      convert(0, 14'h1234, 2'((j % 3) + 1)); // Saturated codes.
    end
    end_test("saturation");
    host.read_begin();
    repeat (3) @(posedge clk);
    #1 check_bit(1'b0, eoc_b); // Stays low under a held read.
    @(posedge clk);
    #1 check_bit(1'b1, eoc_b); // Rises on the fourth edge.
    host.release_bus();
    end_test("end of conversion");
    repeat (20) @(negedge clk) master_clock_in = ~master_clock_in;
    check_bit(1'b1, clock_src_ext); // An applied clock is used.
    master_clock_in = 1'b0;
    repeat (20) @(negedge clk);
    check_bit(1'b0, clock_src_ext); // A pin held low selects the oscillator.
    end_test("clock source");
    @(negedge clk);
    out_ready = 1'b0;
    for (int k = 0; k < 17; k++)
    begin
      seed = xs(seed);
      convert((k < 16) ? 0 : 3, seed[13:0], 2'h0);
    end
    repeat (80) @(negedge clk);
    check_bit(1'b0, tracking);
    out_ready = 1'b1;
    wait_on(1, 40);
    repeat (24) @(negedge clk);
    check_code(14'h0000, 14'(exp_q.size()));
    end_test("buffer");
    convert(3, 14'h0ABC, 2'h0);
    repeat (10) @(negedge clk);
    heavy_on = 1'b0;
    host.soft_reset();
    check_bit(1'b1, eoc_b); // End of conversion goes high.
    check_bit(1'b1, cal_active); // Calibration restarts.
    void'(exp_q.pop_back());
    wait_on(1, 200);
    // A weight that never reads heavy keeps every trim step, so the last bit ends fully trimmed.
    check_code(14'h003F, {8'h00, cal_trim});
    check_code(14'h000D, {10'h000, cal_bit});
    convert(1, 14'h2AAA, 2'h0);
    repeat (3) @(negedge clk);
    check_code(14'h0000, 14'(exp_q.size()));
    end_test("soft reset");
    complete_run();
  end
endmodule

`default_nettype wire
